//--- logic/mlbe_pkg.sv
// Shared types and constants for the logic, branch and bit execution unit.
// Assumes the fetch stage hands over one decoded instruction at a time.
package mlbe_pkg;

  // ****************************************
  // Constants
  // ****************************************
  localparam logic [15:0] PC_RESET      = 16'h0000;
  localparam logic [7:0]  SP_RESET      = 8'h07;
  localparam logic [7:0]  ACC_RESET     = 8'h00;
  localparam logic [3:0]  BIT_AREA_BASE = 4'h2;
  localparam logic [15:0] LEN_TWO       = 16'h0002;
  localparam logic [15:0] LEN_THREE     = 16'h0003;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [5:0] {
    logic_or_op, logic_or_to_dir_op, logic_xor_op, logic_xor_to_dir_op,
    clear_op, invert_op, rotate_left_op, rotate_left_thru_carry_op,
    rotate_right_op, rotate_right_thru_carry_op, page_call_op, long_call_op,
    subroutine_return_op, interrupt_return_op, page_jump_op, long_jump_op,
    relative_jump_op, indirect_jump_op, branch_acc_zero_op,
    branch_acc_nonzero_op, compare_branch_op, decrement_branch_op,
    clear_carry_op, set_carry_op, invert_carry_op, clear_bit_op, set_bit_op,
    invert_bit_op, and_carry_bit_op, and_carry_nbit_op, or_carry_bit_op,
    or_carry_nbit_op, bit_to_carry_op, carry_to_bit_op, branch_carry_set_op,
    branch_carry_clear_op, branch_bit_set_op, branch_bit_clear_op,
    branch_and_clear_bit_op, no_operation
  } mlbe_op_t;

  typedef enum logic [1:0] {SRC_REG, SRC_DIR, SRC_IND, SRC_IMM} mlbe_src_t;

  typedef enum logic {EXEC_FIRST, EXEC_SECOND} mlbe_phase_t;

  typedef struct packed {
    mlbe_op_t    op;
    mlbe_src_t   src;
    logic [2:0]  reg_sel;
    logic [7:0]  dir;
    logic [7:0]  imm;
    logic [7:0]  rel;
    logic [7:0]  bit_addr;
    logic [15:0] addr;
    logic [1:0]  len;
  } mlbe_instr_t;

  // ****************************************
  // Decode helpers
  // ****************************************
  // True for instructions that hold the unit for a second cycle.
  function automatic logic mlbe_two_cycle(mlbe_instr_t i);
    case (i.op)
      logic_or_to_dir_op, logic_xor_to_dir_op: return i.src == SRC_IMM;
      logic_or_op, logic_xor_op, clear_op, invert_op, rotate_left_op,
      rotate_left_thru_carry_op, rotate_right_op, rotate_right_thru_carry_op,
      clear_carry_op, set_carry_op, invert_carry_op, clear_bit_op,
      set_bit_op, invert_bit_op, bit_to_carry_op, no_operation: return 1'b0;
      default: return 1'b1;
    endcase
  endfunction : mlbe_two_cycle

  // True for instructions whose operand is one addressable bit.
  function automatic logic mlbe_is_bit(mlbe_op_t op);
    case (op)
      clear_bit_op, set_bit_op, invert_bit_op, and_carry_bit_op,
      and_carry_nbit_op, or_carry_bit_op, or_carry_nbit_op, bit_to_carry_op,
      carry_to_bit_op, branch_bit_set_op, branch_bit_clear_op,
      branch_and_clear_bit_op: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : mlbe_is_bit

endpackage : mlbe_pkg

//--- logic/mlbe_exec_unit.sv
// Execution unit for logic, rotate, branch, call and bit instructions.
// Assumes an asynchronous-read data memory that captures writes on the edge.
`timescale 1ns/10ps
`default_nettype none
module mlbe_exec_unit
  import mlbe_pkg::*;
(
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // Instruction hand-off from fetch.
  input  wire logic        instr_valid,
  input  wire mlbe_instr_t instr,
  output logic             instr_ready,
  output logic [15:0]      pc,
  // Core state.
  input  wire logic [15:0] data_pointer,
  output logic [7:0]       acc,
  output logic             carry,
  output logic [7:0]       stack_pointer,
  output logic             intr_return_pulse,
  // Data memory, stack and bit space.
  output logic [7:0]       rd0_addr,
  input  wire logic [7:0]  rd0_data,
  output logic [7:0]       rd1_addr,
  input  wire logic [7:0]  rd1_data,
  output logic             wr_en,
  output logic [7:0]       wr_addr,
  output logic [7:0]       wr_data
);

  // ****************************************
  // State and decode
  // ****************************************
  logic [7:0]  acc_q, acc_d, sp_q, sp_d, tmp_q, tmp_d;
  logic        carry_q, carry_d, interrupt_return_op_q, interrupt_return_op_d;
  logic [15:0] pc_q, pc_d, ret_q, ret_d;
  mlbe_phase_t phase_q, phase_d;
  mlbe_instr_t held_q, cur;
  logic        second, go, issue, bit_val;
  logic [7:0]  opnd, bit_byte, oaddr, dir_src, cmp_a, cmp_b, dec;
  logic [15:0] pc_seq, pc_p2, pc_p3, rel_ext;

  // The second cycle replays the held instruction so fetch may move on.
  assign second      = phase_q == EXEC_SECOND;
  assign cur         = second ? held_q : instr;
  assign issue       = instr_valid && !second;
  assign go          = issue || second;
  assign instr_ready = !second;
  assign pc          = pc_q;
  assign acc         = acc_q;
  assign carry       = carry_q;
  assign stack_pointer     = sp_q;
  assign intr_return_pulse = interrupt_return_op_q;

  // Sequential and relative targets.
  assign pc_seq  = pc_q + {14'h0000, cur.len};
  assign pc_p2   = pc_q + LEN_TWO;
  assign pc_p3   = pc_q + LEN_THREE;
  assign rel_ext = {{8{cur.rel[7]}}, cur.rel};

  // Operand addressing; indirect uses the pointer read on port 0.
  always_comb begin
    bit_byte = cur.bit_addr[7] ? {cur.bit_addr[7:3], 3'h0}
                               : {BIT_AREA_BASE, cur.bit_addr[6:3]};
    case (cur.src)
      SRC_REG: oaddr = {5'h00, cur.reg_sel};
      SRC_IND: oaddr = {7'h00, cur.reg_sel[0]};
      default: oaddr = cur.dir;
    endcase
    if (mlbe_is_bit(cur.op)) begin
      rd0_addr = bit_byte;
    end else if (cur.op == subroutine_return_op || cur.op == interrupt_return_op) begin
      rd0_addr = sp_q;
    end else begin
      rd0_addr = oaddr;
    end
  end

  // Operand values seen by the datapath.
  assign rd1_addr = rd0_data;
  assign opnd     = (cur.src == SRC_IND) ? rd1_data :
                    (cur.src == SRC_IMM) ? cur.imm : rd0_data;
  assign dir_src  = (cur.src == SRC_IMM) ? cur.imm : acc_q;
  assign bit_val  = rd0_data[cur.bit_addr[2:0]];
  assign cmp_a    = (cur.src == SRC_DIR || cur.src == SRC_IMM) ? acc_q : opnd;
  assign cmp_b    = (cur.src == SRC_DIR) ? rd0_data : cur.imm;
  assign dec      = rd0_data - 8'h01;

  // ****************************************
  // Execute
  // ****************************************
  // Read-modify-write happens in one cycle because memory reads are
  // combinational; the second cycle moves stack data only for calls and returns.
  always_comb begin
    acc_d = acc_q;
    carry_d = carry_q;
    sp_d = sp_q;
    pc_d = pc_q;
    tmp_d = tmp_q;
    ret_d = ret_q;
    interrupt_return_op_d = 1'b0;
    phase_d = EXEC_FIRST;
    wr_en = 1'b0;
    wr_addr = rd0_addr;
    wr_data = rd0_data;
    if (issue) begin
      if (mlbe_two_cycle(cur)) phase_d = EXEC_SECOND;
      pc_d = pc_seq;
      case (cur.op)
        logic_or_op: acc_d = acc_q | opnd;
        logic_xor_op: acc_d = acc_q ^ opnd;
        logic_or_to_dir_op: begin
          wr_en = 1'b1;
          wr_data = rd0_data | dir_src;
        end
        logic_xor_to_dir_op: begin
          wr_en = 1'b1;
          wr_data = rd0_data ^ dir_src;
        end
        clear_op: acc_d = 8'h00;
        invert_op: acc_d = ~acc_q;
        rotate_left_op: acc_d = {acc_q[6:0], acc_q[7]};
        rotate_right_op: acc_d = {acc_q[0], acc_q[7:1]};
        rotate_left_thru_carry_op: begin
          carry_d = acc_q[7];
          acc_d = {acc_q[6:0], carry_q};
        end
        rotate_right_thru_carry_op: begin
          carry_d = acc_q[0];
          acc_d = {carry_q, acc_q[7:1]};
        end
        page_call_op, long_call_op: begin
          ret_d = (cur.op == page_call_op) ? pc_p2 : pc_p3;
          sp_d = sp_q + 8'h01;
          wr_en = 1'b1;
          wr_addr = sp_d;
          wr_data = ret_d[7:0];
          pc_d = (cur.op == page_call_op) ? {pc_p2[15:11], cur.addr[10:0]}
                                          : cur.addr;
        end
        subroutine_return_op, interrupt_return_op: begin
          tmp_d = rd0_data;
          sp_d = sp_q - 8'h01;
          pc_d = pc_q;
        end
        page_jump_op: pc_d = {pc_p2[15:11], cur.addr[10:0]};
        long_jump_op: pc_d = cur.addr;
        relative_jump_op: pc_d = pc_p2 + rel_ext;
        indirect_jump_op: pc_d = {8'h00, acc_q} + data_pointer;
        branch_acc_zero_op: pc_d = pc_p2 + ((acc_q == 8'h00) ? rel_ext : 16'h0000);
        branch_acc_nonzero_op: pc_d = pc_p2 + ((acc_q != 8'h00) ? rel_ext : 16'h0000);
        compare_branch_op: begin
          carry_d = cmp_a < cmp_b;
          pc_d = pc_p3 + ((cmp_a != cmp_b) ? rel_ext : 16'h0000);
        end
        decrement_branch_op: begin
          wr_en = 1'b1;
          wr_data = dec;
          pc_d = pc_p2 + ((dec != 8'h00) ? rel_ext : 16'h0000);
        end
        clear_carry_op: carry_d = 1'b0;
        set_carry_op: carry_d = 1'b1;
        invert_carry_op: carry_d = ~carry_q;
        clear_bit_op, set_bit_op, invert_bit_op, carry_to_bit_op: begin
          wr_en = 1'b1;
          wr_data[cur.bit_addr[2:0]] = (cur.op == set_bit_op) ? 1'b1 :
                                       (cur.op == invert_bit_op) ? ~bit_val :
                                       (cur.op == carry_to_bit_op) ? carry_q
                                                                   : 1'b0;
        end
        and_carry_bit_op: carry_d = carry_q & bit_val;
        and_carry_nbit_op: carry_d = carry_q & ~bit_val;
        or_carry_bit_op: carry_d = carry_q | bit_val;
        or_carry_nbit_op: carry_d = carry_q | ~bit_val;
        bit_to_carry_op: carry_d = bit_val;
        branch_carry_set_op: pc_d = pc_p2 + (carry_q ? rel_ext : 16'h0000);
        branch_carry_clear_op: pc_d = pc_p2 + (!carry_q ? rel_ext : 16'h0000);
        branch_bit_set_op: pc_d = pc_p3 + (bit_val ? rel_ext : 16'h0000);
        branch_bit_clear_op: pc_d = pc_p3 + (!bit_val ? rel_ext : 16'h0000);
        branch_and_clear_bit_op: begin
          wr_en = bit_val;
          wr_data[cur.bit_addr[2:0]] = 1'b0;
          pc_d = pc_p3 + (bit_val ? rel_ext : 16'h0000);
        end
        default: pc_d = pc_seq;
      endcase
    end else if (second) begin
      case (cur.op)
        page_call_op, long_call_op: begin
          sp_d = sp_q + 8'h01;
          wr_en = 1'b1;
          wr_addr = sp_d;
          wr_data = ret_q[15:8];
        end
        subroutine_return_op, interrupt_return_op: begin
          pc_d = {tmp_q, rd0_data};
          sp_d = sp_q - 8'h01;
          interrupt_return_op_d = cur.op == interrupt_return_op;
        end
        default: pc_d = pc_q;
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // Architectural accumulator and carry.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_q <= ACC_RESET;
      carry_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      carry_q <= carry_d;
    end
  end

  // Program counter and stack pointer.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_q <= PC_RESET;
      sp_q <= SP_RESET;
    end else begin
      pc_q <= pc_d;
      sp_q <= sp_d;
    end
  end

  // Sequencing state carried into the second cycle.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_q <= EXEC_FIRST;
      held_q <= '0;
      ret_q <= 16'h0000;
      tmp_q <= 8'h00;
      interrupt_return_op_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      if (issue) held_q <= instr;
      ret_q <= ret_d;
      tmp_q <= tmp_d;
      interrupt_return_op_q <= interrupt_return_op_d;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  or_imm_acc_a: assert property (
    issue && cur.op == logic_or_op && cur.src == SRC_IMM
    |=> acc_q == ($past(acc_q) | $past(cur.imm)) && instr_ready)
    else $error("OR immediate result or timing wrong");
  dir_imm_wait_a: assert property (
    issue && cur.op == logic_or_to_dir_op && cur.src == SRC_IMM
    |-> wr_en ##1 !instr_ready ##1 instr_ready)
    else $error("OR into direct cell not two cycles");
  xor_acc_a: assert property (
    issue && cur.op == logic_xor_op |=> acc_q == ($past(acc_q) ^ $past(opnd)))
    else $error("XOR result wrong");
  rlc_carry_a: assert property (
    issue && cur.op == rotate_left_thru_carry_op
    |=> carry_q == $past(acc_q[7]) && acc_q[0] == $past(carry_q))
    else $error("Left rotate through carry wrong");
  call_push_a: assert property (
    issue && cur.op == page_call_op
    |-> wr_en && wr_addr == sp_q + 8'h01 && wr_data == pc_p2[7:0]
        ##1 wr_en && wr_data == ret_q[15:8] && sp_q == $past(sp_q) + 8'h01)
    else $error("Call push order wrong");
  jz_taken_a: assert property (
    issue && cur.op == branch_acc_zero_op && acc_q == 8'h00
    |=> pc_q == $past(pc_p2 + rel_ext))
    else $error("Zero branch target wrong");
  cmp_carry_a: assert property (
    issue && cur.op == compare_branch_op && cur.src == SRC_DIR
    |=> carry_q == ($past(acc_q) < $past(rd0_data)))
    else $error("Compare carry wrong");
  decrement_branch_op_write_a: assert property (
    issue && cur.op == decrement_branch_op
    |-> wr_en && wr_data == rd0_data - 8'h01 ##1 !instr_ready)
    else $error("Decrement write wrong");
  ret_pop_a: assert property (
    issue && cur.op == subroutine_return_op
    |-> ##2 sp_q == $past(sp_q, 2) - 8'h02 && instr_ready)
    else $error("Return pop count wrong");

endmodule : mlbe_exec_unit
`default_nettype wire

//--- tb/mlbe_mem_model.sv
// Behavioural data memory, bit space and stack behind the execution unit.
// Assumes the unit reads without a clock and writes on the rising edge.
`timescale 1ns/10ps
`default_nettype none
module mlbe_mem_model (
  // Clock.
  input  wire logic       ref_clk,
  // Read ports.
  input  wire logic [7:0] rd0_addr,
  output logic      [7:0] rd0_data,
  input  wire logic [7:0] rd1_addr,
  output logic      [7:0] rd1_data,
  // Write port.
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_addr,
  input  wire logic [7:0] wr_data
);
  logic [7:0] mem [256];
  // Reads answer in the same cycle, so a slow model is not possible here.
  assign rd0_data = mem[rd0_addr];
  assign rd1_data = mem[rd1_addr];
  // Plain always so that the bench may also preload cells.
  always @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end
endmodule : mlbe_mem_model
`default_nettype wire

//--- tb/mlbe_exec_unit_bench.sv
// Self-checking bench for the logic, branch and bit execution unit.
// Assumes the behavioural memory model stands on the memory ports.
`timescale 1ns/10ps
`default_nettype none
module mlbe_exec_unit_bench
  import mlbe_pkg::*;
;
  logic        ref_clk, reset_n, instr_valid, instr_ready, carry, intr_return_pulse, wr_en;
  mlbe_instr_t instr;
  logic [15:0] pc, data_pointer, ep;
  logic [7:0]  acc, stack_pointer, rd0_addr, rd0_data, rd1_addr, rd1_data, wr_addr, wr_data;
  int          n_errors = 0, checked = 0, cyc = 0;
  // Clock and units.
  always #20 ref_clk = ~ref_clk;
  mlbe_exec_unit dut_u (.ref_clk, .reset_n, .instr_valid, .instr, .instr_ready, .pc,
    .data_pointer, .acc, .carry, .stack_pointer, .intr_return_pulse, .rd0_addr, .rd0_data,
    .rd1_addr, .rd1_data, .wr_en, .wr_addr, .wr_data);
  mlbe_mem_model mem_u (.ref_clk, .rd0_addr, .rd0_data, .rd1_addr, .rd1_data, .wr_en,
    .wr_addr, .wr_data);
  // Ends the run with the counts and the verdict.
  task final_report;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  // A hang is cut short well past the hundred or so cycles the run needs.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Expected pc after a step of n, plus the fixed offset of -16 when taken.
  function automatic logic [15:0] step(input int n, input logic t);
    return ep + 16'(n) + (t ? 16'hFFF0 : 16'h0000);
  endfunction : step
  // Issues one instruction, checks the hold cycle and the next fetch address.
  task automatic run(input mlbe_op_t o, input mlbe_src_t s, input logic [7:0] a,
                     input logic [7:0] b, input logic two, input logic [15:0] ne);
    instr = '{op: o, src: s, reg_sel: a[2:0], dir: a, imm: b, rel: 8'hF0, bit_addr: a,
              addr: {a, b}, len: (o == long_call_op || o == long_jump_op) ? 2'h3 : 2'h2};
    instr_valid = 1'b1;
    @(posedge ref_clk);
    #1;
    // Valid stays up between calls, so it never toggles twice in one step.
    // The unit refuses it during the hold cycle and replays its own copy.
    chk("instr_ready", two ? 16'h0000 : 16'h0001, 16'(instr_ready));
    if (two) begin
      @(posedge ref_clk);
      #1;
    end
    ep = ne;
    chk("pc", ne, pc);
  endtask : run
  task automatic run_acc(input mlbe_op_t o, input mlbe_src_t s, input logic [7:0] a,
                         input logic [7:0] b, input logic [7:0] e);
    run(o, s, a, b, 1'b0, step(2, 1'b0));
    chk("acc", e, acc);
  endtask : run_acc
  // Accumulator logic from every operand source.
  task t_acc;
    mem_u.mem[8'h30] = 8'h0F;
    mem_u.mem[8'h01] = 8'hF0;
    mem_u.mem[8'h00] = 8'h40;
    mem_u.mem[8'h40] = 8'h81;
    run_acc(logic_or_op, SRC_IMM, 8'h00, 8'h5A, 8'h5A);
    run_acc(logic_xor_op, SRC_IMM, 8'h00, 8'hFF, 8'hA5);
    run_acc(logic_xor_op, SRC_DIR, 8'h30, 8'h00, 8'hAA);
    run_acc(logic_xor_op, SRC_REG, 8'h01, 8'h00, 8'h5A);
    run_acc(logic_xor_op, SRC_IND, 8'h00, 8'h00, 8'hDB);
    run_acc(invert_op, SRC_REG, 8'h00, 8'h00, 8'h24);
    run_acc(clear_op, SRC_REG, 8'h00, 8'h00, 8'h00);
  endtask : t_acc
  // Direct cells as destination, immediate taking the longer path.
  task t_dir;
    mem_u.mem[8'h31] = 8'h30;
    run_acc(logic_or_op, SRC_IMM, 8'h00, 8'h41, 8'h41);
    run(logic_or_to_dir_op, SRC_IMM, 8'h31, 8'h0C, 1'b1, step(2, 1'b0));
    chk("cell", 8'h3C, mem_u.mem[8'h31]);
    run(logic_or_to_dir_op, SRC_DIR, 8'h31, 8'h00, 1'b0, step(2, 1'b0));
    chk("cell", 8'h7D, mem_u.mem[8'h31]);
    run(logic_xor_to_dir_op, SRC_IMM, 8'h31, 8'hFF, 1'b1, step(2, 1'b0));
    chk("cell", 8'h82, mem_u.mem[8'h31]);
    run(logic_xor_to_dir_op, SRC_DIR, 8'h31, 8'h00, 1'b0, step(2, 1'b0));
    chk("cell", 8'hC3, mem_u.mem[8'h31]);
  endtask : t_dir
  // Rotates with both end bits set so that a lost wrap shows.
  task t_rot;
    run_acc(clear_carry_op, SRC_REG, 8'h00, 8'h00, 8'h41);
    run_acc(logic_xor_op, SRC_IMM, 8'h00, 8'hC0, 8'h81);
    run_acc(rotate_left_op, SRC_REG, 8'h00, 8'h00, 8'h03);
    run_acc(rotate_right_op, SRC_REG, 8'h00, 8'h00, 8'h81);
    run_acc(rotate_left_thru_carry_op, SRC_REG, 8'h00, 8'h00, 8'h02);
    chk("carry", 16'h0001, 16'(carry));
    run_acc(rotate_right_thru_carry_op, SRC_REG, 8'h00, 8'h00, 8'h81);
    chk("carry", 16'h0000, 16'(carry));
  endtask : t_rot
  // Single-bit work in the low bit area and in the upper space.
  task t_bit;
    run(set_bit_op, SRC_REG, 8'h09, 8'h00, 1'b0, step(2, 1'b0));
    chk("bits", 8'h02, mem_u.mem[8'h21]);
    run(set_bit_op, SRC_REG, 8'hE1, 8'h00, 1'b0, step(2, 1'b0));
    chk("bits", 8'h02, mem_u.mem[8'hE0]);
    run(bit_to_carry_op, SRC_REG, 8'h09, 8'h00, 1'b0, step(2, 1'b0));
    chk("carry", 16'h0001, 16'(carry));
    run(and_carry_nbit_op, SRC_REG, 8'h09, 8'h00, 1'b1, step(2, 1'b0));
    chk("carry", 16'h0000, 16'(carry));
    run(or_carry_bit_op, SRC_REG, 8'h09, 8'h00, 1'b1, step(2, 1'b0));
    chk("carry", 16'h0001, 16'(carry));
    run(carry_to_bit_op, SRC_REG, 8'h0A, 8'h00, 1'b1, step(2, 1'b0));
    chk("bits", 8'h06, mem_u.mem[8'h21]);
    run(and_carry_bit_op, SRC_REG, 8'h08, 8'h00, 1'b1, step(2, 1'b0));
    chk("carry", 16'h0000, 16'(carry));
    run(or_carry_nbit_op, SRC_REG, 8'h08, 8'h00, 1'b1, step(2, 1'b0));
    chk("carry", 16'h0001, 16'(carry));
    run(invert_carry_op, SRC_REG, 8'h00, 8'h00, 1'b0, step(2, 1'b0));
    chk("carry", 16'h0000, 16'(carry));
    run(set_carry_op, SRC_REG, 8'h00, 8'h00, 1'b0, step(2, 1'b0));
    chk("carry", 16'h0001, 16'(carry));
    run(invert_bit_op, SRC_REG, 8'h09, 8'h00, 1'b0, step(2, 1'b0));
    chk("bits", 8'h04, mem_u.mem[8'h21]);
    run(clear_bit_op, SRC_REG, 8'h0A, 8'h00, 1'b0, step(2, 1'b0));
    chk("bits", 8'h00, mem_u.mem[8'h21]);
  endtask : t_bit
  // Accumulator, carry and bit branches, each form once; the bit-clearing branch both taken and not.
  task t_br;
    run(branch_acc_zero_op, SRC_REG, 8'h00, 8'h00, 1'b1, step(2, 1'b0));
    run(branch_acc_nonzero_op, SRC_REG, 8'h00, 8'h00, 1'b1, step(2, 1'b1));
    run(branch_carry_set_op, SRC_REG, 8'h00, 8'h00, 1'b1, step(2, 1'b1));
    run(branch_carry_clear_op, SRC_REG, 8'h00, 8'h00, 1'b1, step(2, 1'b0));
    mem_u.mem[8'h21] = 8'h03;
    run(branch_bit_set_op, SRC_REG, 8'h09, 8'h00, 1'b1, step(3, 1'b1));
    run(branch_bit_clear_op, SRC_REG, 8'h09, 8'h00, 1'b1, step(3, 1'b0));
    run(branch_and_clear_bit_op, SRC_REG, 8'h09, 8'h00, 1'b1, step(3, 1'b1));
    run(branch_and_clear_bit_op, SRC_REG, 8'h09, 8'h00, 1'b1, step(3, 1'b0));
    chk("bits", 8'h01, mem_u.mem[8'h21]);
  endtask : t_br
  // Compares on either side of equality and decrements down to zero.
  task t_cmp;
    mem_u.mem[8'h32] = 8'h90;
    mem_u.mem[8'h02] = 8'h05;
    mem_u.mem[8'h33] = 8'h01;
    run(compare_branch_op, SRC_DIR, 8'h32, 8'h00, 1'b1, step(3, 1'b1));
    chk("carry", 16'h0001, 16'(carry));
    mem_u.mem[8'h32] = 8'h81;
    run(compare_branch_op, SRC_DIR, 8'h32, 8'h00, 1'b1, step(3, 1'b0));
    chk("carry", 16'h0000, 16'(carry));
    run(compare_branch_op, SRC_REG, 8'h02, 8'h06, 1'b1, step(3, 1'b1));
    chk("carry", 16'h0001, 16'(carry));
    run(compare_branch_op, SRC_REG, 8'h02, 8'h05, 1'b1, step(3, 1'b0));
    chk("carry", 16'h0000, 16'(carry));
    run(compare_branch_op, SRC_IMM, 8'h00, 8'hC0, 1'b1, step(3, 1'b1));
    chk("carry", 16'h0001, 16'(carry));
    run(compare_branch_op, SRC_IND, 8'h00, 8'h80, 1'b1, step(3, 1'b1));
    chk("carry", 16'h0000, 16'(carry));
    run(decrement_branch_op, SRC_REG, 8'h02, 8'h00, 1'b1, step(2, 1'b1));
    chk("cell", 8'h04, mem_u.mem[8'h02]);
    run(decrement_branch_op, SRC_DIR, 8'h33, 8'h00, 1'b1, step(2, 1'b0));
    chk("cell", 8'h00, mem_u.mem[8'h33]);
  endtask : t_cmp
  // Calls, returns and jumps through the stack and the pointer.
  task t_call;
    logic [15:0] r;
    r = ep + 16'h0002;
    run(page_call_op, SRC_REG, 8'h03, 8'h21, 1'b1, {r[15:11], 11'h321});
    chk("sp", 8'h09, stack_pointer);
    chk("push", {r[7:0], r[15:8]}, {mem_u.mem[8'h08], mem_u.mem[8'h09]});
    run(subroutine_return_op, SRC_REG, 8'h00, 8'h00, 1'b1, r);
    chk("sp", 8'h07, stack_pointer);
    chk("intr_return_pulse", 16'h0000, 16'(intr_return_pulse));
    r = ep + 16'h0003;
    run(long_call_op, SRC_REG, 8'h45, 8'h67, 1'b1, 16'h4567);
    chk("push", {r[7:0], r[15:8]}, {mem_u.mem[8'h08], mem_u.mem[8'h09]});
    run(interrupt_return_op, SRC_REG, 8'h00, 8'h00, 1'b1, r);
    // The pulse stands for the one cycle after the second pop only.
    chk("intr_return_pulse", 16'h0001, 16'(intr_return_pulse));
    run(long_jump_op, SRC_REG, 8'h12, 8'h34, 1'b1, 16'h1234);
    chk("sp", 8'h07, stack_pointer);
    data_pointer = 16'h1000;
    run(indirect_jump_op, SRC_REG, 8'h00, 8'h00, 1'b1, 16'h1081);
    // Unconditional relative and page jumps, then an idle step.
    run(relative_jump_op, SRC_REG, 8'h00, 8'h00, 1'b1, step(2, 1'b1));
    r = ep + 16'h0002;
    run(page_jump_op, SRC_REG, 8'h05, 8'h55, 1'b1, {r[15:11], 11'h555});
    chk("sp", 8'h07, stack_pointer);
    run(no_operation, SRC_REG, 8'h00, 8'h00, 1'b0, step(2, 1'b0));
  endtask : t_call
  // Reset, then the scenarios in an order that hands state along.
  initial begin
    ref_clk = 1'b0;
    reset_n = 1'b0;
    instr_valid = 1'b0;
    instr = '0;
    data_pointer = 16'h0000;
    ep = PC_RESET;
    for (int k = 0; k < 256; k++) begin
      mem_u.mem[k] = 8'h00;
    end
    repeat (16) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    chk("pc", PC_RESET, pc);
    chk("sp", SP_RESET, stack_pointer);
    chk("acc", ACC_RESET, acc);
    chk("carry", 16'h0000, 16'(carry));
    t_acc();
    t_dir();
    t_rot();
    t_bit();
    t_br();
    t_cmp();
    t_call();
    // A reset in mid-run must restore the state at once, with no clock edge.
    instr_valid = 1'b0;
    reset_n = 1'b0;
    #1;
    chk("pc", PC_RESET, pc);
    chk("sp", SP_RESET, stack_pointer);
    chk("acc", ACC_RESET, acc);
    chk("instr_ready", 16'h0001, 16'(instr_ready));
    final_report();
  end
endmodule : mlbe_exec_unit_bench
`default_nettype wire
